/* tuc_timing_port_config.sv */
/*
 * t1 unit timing and port configuration: alarm choice, master clock
 * selection with fallback, self-test sequencing, panel and port gating.
 * assumes an axi4-lite master on i_sys_clk and clock-good levels
 * synchronous to i_sys_clk.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tuc_timing_port_config #(
    parameter int SELFTEST_CYCLES = tuc_pkg::TUC_SELFTEST_CYC
) (
    input  wire logic        i_sys_clk,        // system clock
    input  wire logic        i_resetn,         // async reset, low
    input  wire logic [7:0]  i_awaddr,         // write address
    input  wire logic        i_awvalid,        // write addr valid
    output logic             o_awready,        // write addr ready
    input  wire logic [31:0] i_wdata,          // write data
    input  wire logic [3:0]  i_wstrb,          // byte strobes
    input  wire logic        i_wvalid,         // write data valid
    output logic             o_wready,         // write data ready
    output logic [1:0]       o_bresp,          // write response
    output logic             o_bvalid,         // write resp valid
    input  wire logic        i_bready,         // write resp ready
    input  wire logic [7:0]  i_araddr,         // read address
    input  wire logic        i_arvalid,        // read addr valid
    output logic             o_arready,        // read addr ready
    output logic [31:0]      o_rdata,          // read data
    output logic [1:0]       o_rresp,          // read response
    output logic             o_rvalid,         // read data valid
    input  wire logic        i_rready,         // read data ready
    input  wire logic        i_net_cfa,        // network carrier failure
    input  wire logic        i_dte_cfa,        // drop/insert carrier failure
    input  wire logic [4:0]  i_clk_good,       // per-source clock good
    input  wire logic        i_ring,           // incoming modem call
    input  wire logic        i_selftest_pass,  // self-test result
    output logic             o_net_yellow,     // yellow to network
    output logic             o_dte_yellow,     // yellow to drop/insert
    output logic             o_dte_ais,        // ais to drop/insert
    output logic [2:0]       o_master_src,     // source in use
    output logic             o_fallback,       // on internal fallback
    output logic [1:0]       o_ext_rate,       // external input rate
    output logic             o_selftest_run,   // self-test running
    output logic             o_answer,         // answer modem call
    output logic             o_pw_modem,       // prompt on modem port
    output logic             o_pw_com,         // prompt on com port
    output logic             o_panel_enable,   // panel access/display
    output logic             o_dialout_avail,  // pass-through dial-out
    output logic             o_com_sync,       // com port synchronous
    output logic             o_com_clk_in,     // com clock is input
    output logic [2:0]       o_com_rate,       // active com rate
    output logic             o_shared_port_owner // shared port owner
);
    import tuc_pkg::*;

    initial begin
        if (SELFTEST_CYCLES < 1) $error("SELFTEST_CYCLES must be >= 1");
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [31:0] cfg;
    logic [31:0] prt;
    logic [2:0]  active_rate;
    logic [2:0]  sel_src;
    logic        sel_valid;
    logic [2:0]  fail_src;
    logic        in_fallback;
    tuc_st_type  st_state;
    logic [31:0] st_cnt;
    logic        st_fail;
    logic        st_done;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic [31:0] wr_merge;
    logic [31:0] wr_base;
    logic        wr_hit;

    assign wr_go = aw_held && w_held && !o_bvalid;

    // address and data latch in either order
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end else begin
            o_awready <= !aw_held && !o_awready && i_awvalid;
            o_wready  <= !w_held && !o_wready && i_wvalid;
            if (o_awready && i_awvalid) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (o_wready && i_wvalid) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // byte-lane merge onto the addressed register
    always_comb begin
        wr_hit  = 1'b1;
        wr_base = 32'h0000_0000;
        case (aw_addr)
            TUC_ADDR_CFG:  wr_base = cfg;
            TUC_ADDR_PORT: wr_base = prt;
            TUC_ADDR_SAVE: wr_base = 32'h0000_0000;
            default:       wr_hit  = 1'b0;
        endcase
        for (int b = 0; b < 4; b++) begin
            wr_merge[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8]
                                           : wr_base[b*8 +: 8];
        end
    end

    // write response
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= TUC_RESP_OK;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? TUC_RESP_OK : TUC_RESP_ERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers with write-time screening
    // ------------------------------------------------------------
    logic [2:0] wsrc;
    logic [1:0] wcuse;
    logic [1:0] wmuse;
    logic       wsync;
    logic [2:0] wrate;
    logic       src_ok;
    logic       prt_ok;

    always_comb begin
        wsrc  = wr_merge[TUC_CFG_SRC_LO +: 3];
        wcuse = wr_merge[TUC_PRT_CUSE_LO +: 2];
        wmuse = wr_merge[TUC_PRT_MUSE_LO +: 2];
        wsync = wr_merge[TUC_PRT_CSYNC];
        wrate = wr_merge[TUC_PRT_RATE_LO +: 3];
        // only the five documented sources are legal, dte only with drop/insert enabled
        src_ok = (wsrc <= TUC_SRC_EXT)
              && !(wsrc == TUC_SRC_DTE && !wr_merge[TUC_CFG_DIEN])
              && (wr_merge[TUC_CFG_RAT_LO +: 2] <= TUC_EXT_8K);
        prt_ok = !(wcuse == TUC_USE_SNMP && wmuse == TUC_USE_SNMP)
              && !(wsync && wcuse != TUC_USE_SNMP)
              && (wcuse <= TUC_USE_TERM) && (wmuse <= TUC_USE_TERM)
              && (wrate <= TUC_BPS_19200)
              && !(wsync && wrate == TUC_BPS_1200);
    end

    // illegal settings are dropped, register keeps its value
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg <= TUC_CFG_RESET;
            prt <= TUC_PRT_RESET;
        end else if (wr_go) begin
            if (aw_addr == TUC_ADDR_CFG && src_ok)
                cfg <= wr_merge;
            if (aw_addr == TUC_ADDR_PORT && prt_ok)
                prt <= wr_merge;
        end
    end

    // rate takes effect only on save
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            active_rate <= TUC_BPS_9600;
        end else if (wr_go && aw_addr == TUC_ADDR_SAVE && wr_merge[0]) begin
            active_rate <= prt[TUC_PRT_RATE_LO +: 3];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [31:0] status;

    assign status = {19'h0, st_done, st_fail, fail_src, in_fallback,
                     active_rate, o_master_src, 1'b0};

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= TUC_RESP_OK;
        end else begin
            o_arready <= !o_arready && !o_rvalid && i_arvalid;
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rresp  <= TUC_RESP_OK;
                case (i_araddr)
                    TUC_ADDR_CFG:    o_rdata <= cfg;
                    TUC_ADDR_PORT:   o_rdata <= prt;
                    TUC_ADDR_SAVE:   o_rdata <= 32'h0000_0000;
                    TUC_ADDR_STATUS: o_rdata <= status;
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= TUC_RESP_ERR;
                    end
                endcase
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm generation
    // ------------------------------------------------------------
    logic cfa_any;
    assign cfa_any = i_net_cfa || i_dte_cfa;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_net_yellow <= 1'b0;
            o_dte_yellow <= 1'b0;
            o_dte_ais    <= 1'b0;
        end else if (!cfg[TUC_CFG_DIEN]) begin
            o_net_yellow <= cfa_any;
            o_dte_yellow <= 1'b0;
            o_dte_ais    <= 1'b0;
        end else if (cfg[TUC_CFG_YEL]) begin
            o_net_yellow <= cfa_any;
            o_dte_yellow <= cfa_any;
            o_dte_ais    <= 1'b0;
        end else begin
            o_net_yellow <= 1'b0;
            o_dte_yellow <= 1'b0;
            o_dte_ais    <= i_net_cfa;
        end
    end

    // ------------------------------------------------------------
    // master clock selection with fallback that clears on reselection or restore
    // ------------------------------------------------------------
    assign sel_src   = cfg[TUC_CFG_SRC_LO +: 3];
    assign sel_valid = !(sel_src == TUC_SRC_DTE && !cfg[TUC_CFG_DIEN]);

    // reselection or restored source leaves fallback
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            in_fallback  <= 1'b0;
            fail_src     <= TUC_SRC_NET;
            o_master_src <= TUC_SRC_NET;
            o_fallback   <= 1'b0;
            o_ext_rate   <= TUC_EXT_2048;
        end else begin
            if (!in_fallback && (!sel_valid || !i_clk_good[sel_src])) begin
                in_fallback <= 1'b1;
                fail_src    <= sel_src;
            end else if (in_fallback && sel_valid
                         && (sel_src != fail_src || i_clk_good[sel_src])) begin
                in_fallback <= 1'b0;
            end
            // one source feeds every derived clock
            o_master_src <= in_fallback ? TUC_SRC_INT : sel_src;
            o_fallback   <= in_fallback;
            // rate only matters in external mode, derived clocks fixed
            o_ext_rate   <= cfg[TUC_CFG_RAT_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // self-test sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_state <= TUC_ST_IDLE;
            st_cnt   <= 32'h0000_0000;
            st_fail  <= 1'b0;
            st_done  <= 1'b0;
        end else begin
            case (st_state)
                TUC_ST_IDLE: begin
                    // decided once after each reset
                    st_state <= cfg[TUC_CFG_STEN] ? TUC_ST_RUN : TUC_ST_DONE;
                    st_cnt   <= 32'h0000_0000;
                end
                TUC_ST_RUN: begin
                    st_cnt <= st_cnt + 32'h0000_0001;
                    if (st_cnt == 32'(SELFTEST_CYCLES - 1)) begin
                        st_fail  <= !i_selftest_pass;
                        st_done  <= 1'b1;
                        st_state <= TUC_ST_DONE;
                    end
                end
                TUC_ST_DONE: st_done <= 1'b1;
                default:     st_state <= TUC_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // user interface gating and com port setup
    // ------------------------------------------------------------
    logic [1:0] pw_mode;
    assign pw_mode = cfg[TUC_CFG_PW_LO +: 2];

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_selftest_run      <= 1'b0;
            o_answer            <= 1'b0;
            o_pw_modem          <= 1'b0;
            o_pw_com            <= 1'b0;
            o_panel_enable      <= 1'b0;
            o_dialout_avail     <= 1'b0;
            o_com_sync          <= 1'b0;
            o_com_clk_in        <= 1'b0;
            o_com_rate          <= TUC_BPS_9600;
            o_shared_port_owner <= 1'b0;
        end else begin
            o_selftest_run  <= (st_state == TUC_ST_RUN);
            o_answer        <= i_ring && cfg[TUC_CFG_DIAL];
            o_pw_modem      <= pw_mode == TUC_PW_MODEM
                            || pw_mode == TUC_PW_BOTH;
            o_pw_com        <= pw_mode == TUC_PW_COM
                            || pw_mode == TUC_PW_BOTH;
            o_panel_enable  <= cfg[TUC_CFG_PANEL];
            o_dialout_avail <= cfg[TUC_CFG_PASS];
            o_com_sync      <= prt[TUC_PRT_CSYNC];
            o_com_clk_in    <= prt[TUC_PRT_CSYNC]
                            && prt[TUC_PRT_CEXT];
            o_com_rate      <= active_rate;
            o_shared_port_owner <= cfg[TUC_CFG_OWNER];
        end
    end

endmodule : tuc_timing_port_config

/* tuc_pkg.sv */
/*
 * constants, encodings and register map for the t1 unit timing and port
 * configuration block.
 * assumes a 32-bit axi4-lite register bus and a single 50 mhz clock.
 */
package tuc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TUC_ADDR_CFG    = 8'h00;
    localparam logic [7:0] TUC_ADDR_PORT   = 8'h04;
    localparam logic [7:0] TUC_ADDR_SAVE   = 8'h08;
    localparam logic [7:0] TUC_ADDR_STATUS = 8'h0c;

    // ------------------------------------------------------------
    // cfg register fields
    // ------------------------------------------------------------
    localparam int TUC_CFG_YEL    = 0;
    localparam int TUC_CFG_DIEN   = 1;
    localparam int TUC_CFG_SRC_LO = 2;   // 3 bits
    localparam int TUC_CFG_RAT_LO = 5;   // 2 bits
    localparam int TUC_CFG_STEN   = 7;
    localparam int TUC_CFG_PANEL  = 8;
    localparam int TUC_CFG_PASS   = 9;
    localparam int TUC_CFG_DIAL   = 10;
    localparam int TUC_CFG_PW_LO  = 11;  // 2 bits
    localparam int TUC_CFG_OWNER  = 13;
    localparam logic [31:0] TUC_CFG_RESET = 32'h0000_01a3;

    // ------------------------------------------------------------
    // port register fields
    // ------------------------------------------------------------
    localparam int TUC_PRT_CUSE_LO = 0;  // 2 bits
    localparam int TUC_PRT_MUSE_LO = 2;  // 2 bits
    localparam int TUC_PRT_CSYNC   = 4;
    localparam int TUC_PRT_CEXT    = 5;
    localparam int TUC_PRT_RATE_LO = 6;  // 3 bits
    localparam logic [31:0] TUC_PRT_RESET = 32'h0000_00c5;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TUC_SRC_NET = 3'h0, TUC_SRC_DTE = 3'h1, TUC_SRC_PORT1 = 3'h2,
        TUC_SRC_INT = 3'h3, TUC_SRC_EXT = 3'h4
    } tuc_src_type;
    typedef enum logic [1:0] {
        TUC_EXT_2048 = 2'h0, TUC_EXT_1544 = 2'h1, TUC_EXT_8K = 2'h2
    } tuc_ext_rate_type;
    typedef enum logic [1:0] {
        TUC_USE_SNMP = 2'h0, TUC_USE_ASCII = 2'h1, TUC_USE_TERM = 2'h2
    } tuc_use_type;
    typedef enum logic [2:0] {
        TUC_BPS_1200 = 3'h0, TUC_BPS_2400 = 3'h1, TUC_BPS_4800 = 3'h2,
        TUC_BPS_9600 = 3'h3, TUC_BPS_14400 = 3'h4, TUC_BPS_19200 = 3'h5
    } tuc_bps_type;
    typedef enum logic [1:0] {
        TUC_ST_IDLE = 2'h0, TUC_ST_RUN = 2'h1, TUC_ST_DONE = 2'h3
    } tuc_st_type;

    localparam logic [1:0] TUC_PW_MODEM = 2'h1;
    localparam logic [1:0] TUC_PW_COM   = 2'h2;
    localparam logic [1:0] TUC_PW_BOTH  = 2'h3;
    localparam logic [1:0] TUC_RESP_OK  = 2'h0;
    localparam logic [1:0] TUC_RESP_ERR = 2'h2;
    localparam int TUC_PW_MAX_CHARS = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TUC_CLK_MHZ     = 50;
    localparam int TUC_SELFTEST_US = 10;
    localparam int TUC_SELFTEST_CYC = TUC_SELFTEST_US * TUC_CLK_MHZ;

endpackage : tuc_pkg

/* tuc_props.sv */
/* assertions on the timing and port configuration block, bound to its
   top module. assumes one clock and an active-low async reset. */
`timescale 1ns/1ps
module tuc_props #(
    parameter int SELFTEST_CYCLES = tuc_pkg::TUC_SELFTEST_CYC
) (
    input wire logic       i_sys_clk,      // clock
    input wire logic       i_resetn,       // reset, low
    input wire logic       i_net_cfa,      // net failure
    input wire logic       i_dte_cfa,      // dte failure
    input wire logic       i_ring,         // call
    input wire logic       o_bvalid,       // write resp
    input wire logic       o_net_yellow,   // net yellow
    input wire logic       o_dte_yellow,   // dte yellow
    input wire logic       o_dte_ais,      // dte ais
    input wire logic [2:0] o_master_src,   // source used
    input wire logic       o_fallback,     // fallback
    input wire logic       o_selftest_run, // self-test
    input wire logic       o_answer,       // answer
    input wire logic       o_com_sync,     // com sync
    input wire logic       o_com_clk_in,   // com clk in
    input wire logic [2:0] o_com_rate      // com rate
);
    int   run_len;
    logic any_cfa;
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    assign any_cfa = i_net_cfa | i_dte_cfa;
    // length of the current self-test run
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) run_len <= 0;
        else if (o_selftest_run) run_len <= run_len + 1;
        else run_len <= 0;
    end
    a_ais_excl:
        assert property (!(o_dte_ais && o_dte_yellow))
        else $error("ais with yellow");
    a_ais_cause:
        assert property (o_dte_ais |-> $past(i_net_cfa))
        else $error("ais without net failure");
    a_yel_cause:
        assert property (o_net_yellow |-> $past(any_cfa))
        else $error("yellow without failure");
    a_yel_pair:
        assert property (o_dte_yellow |-> o_net_yellow)
        else $error("dte yellow alone");
    a_answer_ring:
        assert property (o_answer |-> $past(i_ring))
        else $error("answer without call");
    a_fb_src:
        assert property (o_fallback ##1 o_fallback |-> o_master_src == 3'h3)
        else $error("fallback not internal");
    a_clk_in_sync:
        assert property (o_com_clk_in |-> o_com_sync)
        else $error("clock input while async");
    a_rate_save:
        assert property ($changed(o_com_rate) |-> o_bvalid || $past(o_bvalid))
        else $error("rate changed without save");
    a_st_max:
        assert property (run_len <= SELFTEST_CYCLES + 1)
        else $error("self-test too long");
    a_st_min:
        assert property ($fell(o_selftest_run) |-> run_len >= SELFTEST_CYCLES - 1)
        else $error("self-test too short");
    c_fallback: cover property ($rose(o_fallback));
    c_ais: cover property (o_dte_ais);
    c_clk_in: cover property (o_com_clk_in);
    c_answer: cover property (o_answer);
endmodule : tuc_props
bind tuc_timing_port_config tuc_props #(
    .SELFTEST_CYCLES(SELFTEST_CYCLES)) u_props (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_net_cfa(i_net_cfa),
    .i_dte_cfa(i_dte_cfa), .i_ring(i_ring), .o_bvalid(o_bvalid),
    .o_net_yellow(o_net_yellow), .o_dte_yellow(o_dte_yellow),
    .o_dte_ais(o_dte_ais), .o_master_src(o_master_src),
    .o_fallback(o_fallback), .o_selftest_run(o_selftest_run),
    .o_answer(o_answer), .o_com_sync(o_com_sync),
    .o_com_clk_in(o_com_clk_in), .o_com_rate(o_com_rate));

/* tuc_far_end.sv */
/* far end: network line and drop/insert equipment giving carrier
   failure, clock health and calls. assumes the system clock. */
`timescale 1ns/1ps
module tuc_far_end (
    input  wire logic       i_clk,      // clock
    input  wire logic [1:0] i_cfa,      // fail net, dte
    input  wire logic [4:0] i_fail,     // dead sources
    input  wire logic       i_call,     // place call
    output logic            o_net_cfa,  // net failure
    output logic            o_dte_cfa,  // dte failure
    output logic [4:0]      o_clk_good, // clock health
    output logic            o_ring      // incoming call
);
    // line state follows commands one cycle later
    always_ff @(posedge i_clk) begin
        o_net_cfa <= i_cfa[0];
        o_dte_cfa <= i_cfa[1];
        o_clk_good <= ~i_fail;
        o_ring <= i_call;
    end
endmodule : tuc_far_end

/* test_tuc_timing_port_config.sv */
/* self-checking bench: an integer model is compared with the alarm, clock,
   panel and port outputs. assumes tuc_far_end stands for the line side. */
`timescale 1ns/1ps
module test_tuc_timing_port_config;
    import tuc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, call_cmd = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [1:0]  cfa_cmd = 2'h0, bresp, rresp, ext_rate;
    logic [4:0]  fail_cmd = 5'h00, clk_good;
    logic [2:0]  msrc, crate;
    logic        awready, wready, bvalid, arready, rvalid, net_cfa, dte_cfa;
    logic        ring, net_y, dte_y, ais, fb, st_run, answer, pw_m, pw_c;
    logic        panel, dialout, sync, clk_in, owner;
    int          miscompares = 0, n_tests = 0, i, w;
    int          cfg_m = 32'h1a3, prt_m = 32'hc5, rate_m = 3;
    int          ptab[6] = '{32'hc8, 32'hc0, 32'hf8, 32'h38, 32'hd5, 32'h45};
    always #10 clk = ~clk;
    tuc_timing_port_config #(.SELFTEST_CYCLES(4)) uut (
        .i_sys_clk(clk), .i_resetn(rstn), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_net_cfa(net_cfa), .i_dte_cfa(dte_cfa),
        .i_clk_good(clk_good), .i_ring(ring), .i_selftest_pass(1'b1),
        .o_net_yellow(net_y), .o_dte_yellow(dte_y), .o_dte_ais(ais),
        .o_master_src(msrc), .o_fallback(fb), .o_ext_rate(ext_rate),
        .o_selftest_run(st_run), .o_answer(answer), .o_pw_modem(pw_m),
        .o_pw_com(pw_c), .o_panel_enable(panel),
        .o_dialout_avail(dialout), .o_com_sync(sync),
        .o_com_clk_in(clk_in), .o_com_rate(crate),
        .o_shared_port_owner(owner));
    tuc_far_end far (.i_clk(clk), .i_cfa(cfa_cmd), .i_fail(fail_cmd),
        .i_call(call_cmd), .o_net_cfa(net_cfa), .o_dte_cfa(dte_cfa),
        .o_clk_good(clk_good), .o_ring(ring));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_tests++;
        if (e !== s) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask : tmo
    // write with both channels offered at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        tmo(n);
        bready <= 1'b0;
        chk("bresp", er, bresp);
    endtask : wr
    // read; rready offered with the address
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        tmo(n);
        rready <= 1'b0;
        chk("rdata", e, rdata & m);
        chk("rresp", er, rresp);
    endtask : rd
    // model outputs against the design
    task automatic chk_all();
        logic den, yel, f;
        repeat (4) @(posedge clk);
        den = cfg_m[1];
        yel = cfg_m[0];
        f = fail_cmd[cfg_m[4:2]];
        chk("outs", {(!den || yel) && cfa_cmd != 0, den && yel && cfa_cmd != 0,
            den && !yel && cfa_cmd[0], f, f ? 3'h3 : 3'(cfg_m[4:2]),
            cfg_m[6:5], call_cmd && cfg_m[10], cfg_m[12:11], cfg_m[9:8],
            prt_m[4], prt_m[4] && prt_m[5], 3'(rate_m), cfg_m[13]},
            {net_y, dte_y, ais, fb, msrc, ext_rate, answer, pw_c, pw_m,
            dialout, panel, sync, clk_in, crate, owner});
    endtask : chk_all
    task automatic wcfg(input int d);
        wr(TUC_ADDR_CFG, d, TUC_RESP_OK);
        if (d[4:2] < 5 && !(d[4:2] == 1 && !d[1]) && d[6:5] < 3)
            cfg_m = d;
        chk_all();
    endtask : wcfg
    task automatic wprt(input int d);
        wr(TUC_ADDR_PORT, d, TUC_RESP_OK);
        if (d[1:0] < 3 && d[3:2] < 3 && d[3:0] != 0 && d[8:6] < 6 &&
            !(d[4] && (d[1:0] != 0 || d[8:6] == 0)))
            prt_m = d;
        chk_all();
        wr(TUC_ADDR_SAVE, 32'h1, TUC_RESP_OK);
        rate_m = prt_m[8:6];
        chk_all();
    endtask : wprt
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        void'($urandom(32'h90583c66));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("st_run", 1'b1, st_run);
        repeat (10) @(posedge clk);
        rd(TUC_ADDR_STATUS, 32'h1030, 32'h18fe, TUC_RESP_OK);
        rd(TUC_ADDR_CFG, 32'h1a3, 32'hffffffff, TUC_RESP_OK);
        rd(TUC_ADDR_PORT, 32'hc5, 32'hffffffff, TUC_RESP_OK);
        chk_all();
        wr(8'h10, 32'h0, TUC_RESP_ERR);
        rd(8'h10, 32'h0, 32'hffffffff, TUC_RESP_ERR);
        for (i = 0; i < 24; i++) begin
            if (i % 8 == 0) wcfg(32'h1a3 - i / 8);
            cfa_cmd <= 2'($urandom);
            call_cmd <= 1'($urandom);
            chk_all();
        end
        cfa_cmd <= 2'h0;
        for (i = 0; i < 16; i++) begin
            wcfg((32'h1a3 - i / 8 * 2) | (i % 8) << 2);
            rd(TUC_ADDR_CFG, cfg_m, 32'hffffffff, TUC_RESP_OK);
        end
        for (i = 0; i < 4; i++)
            wcfg(32'h193 | i << 5);
        wcfg(32'h1a3);
        fail_cmd <= 5'h01;
        chk_all();
        chk_all();
        fail_cmd <= 5'h00;
        chk_all();
        for (i = 0; i < 24; i++) begin
            call_cmd <= 1'($urandom);
            w = ($urandom & 32'h27e3) | (i % 4) << 11;
            wcfg(w);
        end
        foreach (ptab[k])
            wprt(ptab[k]);
        for (i = 0; i < 16; i++)
            wprt($urandom & 32'h1ff);
        conclude();
    end
endmodule : test_tuc_timing_port_config
